// File: design/pio_line_ctrl.sv
// top of the parallel I/O line controller: register port, line muxing, interrupts
// assumes pins sampled in the mclk domain and a single-cycle register master
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
module pio_line_ctrl
    import pio_line_pkg::*;
(
    input  wire logic                 mclk,         // 40 MHz system clock
    input  wire logic                 rst_b,        // async reset, active low
    input  wire logic [ADDR_W-1:0]    reg_addr,     // byte address
    input  wire logic [31:0]          reg_wdata,    // write data
    input  wire logic                 reg_wr,       // write strobe
    input  wire logic                 reg_rd,       // read strobe
    output logic      [31:0]          reg_rdata,    // read data, cycle after strobe
    input  wire logic [NUM_LINES-1:0] pin_in,       // pad input levels
    output logic      [NUM_LINES-1:0] pin_out,      // pad output levels
    output logic      [NUM_LINES-1:0] pin_oe,       // pad drive enables
    output logic      [NUM_LINES-1:0] pin_pullup,   // pad pull-up enables
    input  wire logic [NUM_LINES-1:0] periph_out,   // peripheral output data
    input  wire logic [NUM_LINES-1:0] periph_oe,    // peripheral drive enables
    output logic      [NUM_LINES-1:0] periph_in,    // levels to peripherals
    output logic                      irq           // level interrupt, high active
);
    reg_req_s             req;
    logic [NUM_LINES-1:0] wmask;
    logic [NUM_LINES-1:0] own_q, drv_q, filt_q, out_q, mask_q, pend_q, od_q, pu_q, ow_q;
    logic [NUM_LINES-1:0] level, level_q, change;
    logic                 pend_read;

    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;
    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;

    // only implemented lines can be touched
    assign wmask = req.wdata & LINES_PRESENT;

    function automatic logic [NUM_LINES-1:0] set_clr(
        input logic [NUM_LINES-1:0] cur,
        input logic                 is_set,
        input logic                 is_clr,
        input logic [NUM_LINES-1:0] m
    );
        logic [NUM_LINES-1:0] r;
        r = cur;
        if (is_set) r = cur | m;
        if (is_clr) r = cur & ~m;
        return r;
    endfunction : set_clr

    // ownership: unmuxed lines forced to controller
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            own_q <= LINE_CTRL_RESET;
        end else if (req.wr) begin
            own_q <= set_clr(own_q, req.addr == LINE_CTRL_ENABLE,
                             req.addr == LINE_CTRL_DISABLE, wmask & LINES_MUXED);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            drv_q <= RESET_ZERO;
        end else if (req.wr) begin
            drv_q <= set_clr(drv_q, req.addr == DRIVE_ENABLE_SET,
                             req.addr == DRIVE_ENABLE_CLEAR, wmask);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            filt_q <= RESET_ZERO;
        end else if (req.wr) begin
            filt_q <= set_clr(filt_q, req.addr == GLITCH_FILTER_SET,
                              req.addr == GLITCH_FILTER_CLEAR, wmask);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ow_q <= RESET_ZERO;
        end else if (req.wr) begin
            ow_q <= set_clr(ow_q, req.addr == OUT_WRITE_ENABLE,
                            req.addr == OUT_WRITE_DISABLE, wmask);
        end
    end

    // direct write touches only lines opened in the output write mask
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            out_q <= RESET_ZERO;
        end else if (req.wr && req.addr == OUT_LEVEL_STATE) begin
            out_q <= (out_q & ~(ow_q & LINES_PRESENT))
                   | (req.wdata & ow_q & LINES_PRESENT);
        end else if (req.wr) begin
            out_q <= set_clr(out_q, req.addr == OUT_LEVEL_SET,
                             req.addr == OUT_LEVEL_CLEAR, wmask);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mask_q <= RESET_ZERO;
        end else if (req.wr) begin
            mask_q <= set_clr(mask_q, req.addr == IRQ_ENABLE_SET,
                              req.addr == IRQ_ENABLE_CLEAR, wmask);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            od_q <= RESET_ZERO;
        end else if (req.wr) begin
            od_q <= set_clr(od_q, req.addr == OPEN_DRAIN_SET,
                            req.addr == OPEN_DRAIN_CLEAR, wmask);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pu_q <= RESET_ZERO;
        end else if (req.wr) begin
            pu_q <= set_clr(pu_q, req.addr == PULLUP_SET,
                            req.addr == PULLUP_CLEAR, wmask);
        end
    end

    pio_glitch_filter u_filter (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .raw_in    (pin_in),
        .filt_en   (filt_q),
        .level_out (level)
    );

    // input change detection feeds the sticky pending bits
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            level_q <= RESET_ZERO;
        end else begin
            level_q <= level;
        end
    end

    assign change    = (level ^ level_q) & LINES_PRESENT;
    assign pend_read = req.rd && req.addr == IRQ_PENDING_STATE;

    // a change in the clearing read cycle survives: set wins over clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q <= RESET_ZERO;
        end else if (pend_read) begin
            pend_q <= change;
        end else begin
            pend_q <= pend_q | change;
        end
    end

    assign irq = |(pend_q & mask_q);

    // pad muxing; open drain only drives low
    logic [NUM_LINES-1:0] drv_data, drv_en;
    assign drv_data   = (own_q & out_q) | (~own_q & periph_out);
    assign drv_en     = (own_q & drv_q) | (~own_q & periph_oe);
    assign pin_out    = drv_data & ~od_q;
    assign pin_oe     = drv_en & ~(od_q & drv_data);
    assign pin_pullup = pu_q;
    assign periph_in  = level;

    // read mux
    logic [31:0] rd_d;
    always_comb begin
        rd_d = RESET_ZERO;
        case (req.addr)
            LINE_CTRL_STATUS:    rd_d = own_q | ~LINES_MUXED;
            DRIVE_ENABLE_STATE:  rd_d = drv_q;
            GLITCH_FILTER_STATE: rd_d = filt_q;
            OUT_LEVEL_STATE:     rd_d = out_q;
            PIN_LEVEL_STATE:     rd_d = level;
            IRQ_MASK_STATE:      rd_d = mask_q;
            IRQ_PENDING_STATE:   rd_d = pend_q;
            OPEN_DRAIN_STATE:    rd_d = od_q;
            PULLUP_STATE:        rd_d = pu_q;
            OUT_WRITE_STATE:     rd_d = ow_q;
            default:             rd_d = RESET_ZERO;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= RESET_ZERO;
        end else if (req.rd) begin
            reg_rdata <= rd_d & LINES_PRESENT;
        end else begin
            reg_rdata <= RESET_ZERO;
        end
    end

    sequence s_read(logic [7:0] a);
        req.rd && req.addr == a;
    endsequence

    AST_OWN_UNMUXED: assert property (@(posedge mclk) disable iff (!rst_b)
        s_read(LINE_CTRL_STATUS) |=> ((reg_rdata & ~LINES_MUXED & LINES_PRESENT)
                                     == (~LINES_MUXED & LINES_PRESENT)))
        else $error("unmuxed line not reported as owned");
    AST_UNIMPL_ZERO: assert property (@(posedge mclk) disable iff (!rst_b)
        (reg_rdata & ~LINES_PRESENT) == RESET_ZERO)
        else $error("unimplemented line read nonzero");
    AST_FILT_SET: assert property (@(posedge mclk) disable iff (!rst_b)
        req.wr && req.addr == GLITCH_FILTER_SET |=> ((filt_q & $past(wmask)) == $past(wmask)))
        else $error("filter enable write not applied");
    AST_FILT_CLR: assert property (@(posedge mclk) disable iff (!rst_b)
        req.wr && req.addr == GLITCH_FILTER_CLEAR |=> ((filt_q & $past(wmask)) == RESET_ZERO))
        else $error("filter disable write not applied");
    AST_PU_SET_READ: assert property (@(posedge mclk) disable iff (!rst_b)
        req.wr && req.addr == PULLUP_SET ##2 s_read(PULLUP_STATE)
        |=> ((reg_rdata & $past(wmask, 3)) == $past(wmask, 3)))
        else $error("pull-up enable not visible in state");
    AST_PU_CLR: assert property (@(posedge mclk) disable iff (!rst_b)
        req.wr && req.addr == PULLUP_CLEAR |=> ((pin_pullup & $past(wmask)) == RESET_ZERO))
        else $error("pull-up disable write not applied");
    AST_DIRECT_WR: assert property (@(posedge mclk) disable iff (!rst_b)
        req.wr && req.addr == OUT_LEVEL_STATE
        |=> ((out_q & $past(ow_q) & LINES_PRESENT)
            == ($past(req.wdata) & $past(ow_q) & LINES_PRESENT))
            && ((out_q & ~$past(ow_q)) == ($past(out_q) & ~$past(ow_q))))
        else $error("direct output write wrong");
    AST_ZERO_NOEFFECT: assert property (@(posedge mclk) disable iff (!rst_b)
        req.wr && req.addr == DRIVE_ENABLE_SET |=> ((drv_q & ~$past(wmask))
                                                   == ($past(drv_q) & ~$past(wmask))))
        else $error("zero bits changed drive state");
    AST_UNIMPL_WR: assert property (@(posedge mclk) disable iff (!rst_b)
        req.wr |=> ((mask_q & ~LINES_PRESENT) == ($past(mask_q) & ~LINES_PRESENT)))
        else $error("unimplemented bit changed");
endmodule : pio_line_ctrl

// File: design/pio_line_pkg.sv
// register map, reset values and field positions of the parallel I/O line controller
// assumes a 32-bit register port with byte addresses on aligned words
package pio_line_pkg;
    localparam int          NUM_LINES          = 32;
    localparam int          ADDR_W             = 8;
    localparam logic [7:0]  LINE_CTRL_ENABLE   = 8'h00;
    localparam logic [7:0]  LINE_CTRL_DISABLE  = 8'h04;
    localparam logic [7:0]  LINE_CTRL_STATUS   = 8'h08;
    localparam logic [7:0]  DRIVE_ENABLE_SET   = 8'h10;
    localparam logic [7:0]  DRIVE_ENABLE_CLEAR = 8'h14;
    localparam logic [7:0]  DRIVE_ENABLE_STATE = 8'h18;
    localparam logic [7:0]  GLITCH_FILTER_SET  = 8'h20;
    localparam logic [7:0]  GLITCH_FILTER_CLEAR= 8'h24;
    localparam logic [7:0]  GLITCH_FILTER_STATE= 8'h28;
    localparam logic [7:0]  OUT_LEVEL_SET      = 8'h30;
    localparam logic [7:0]  OUT_LEVEL_CLEAR    = 8'h34;
    localparam logic [7:0]  OUT_LEVEL_STATE    = 8'h38;
    localparam logic [7:0]  PIN_LEVEL_STATE    = 8'h3C;
    localparam logic [7:0]  IRQ_ENABLE_SET     = 8'h40;
    localparam logic [7:0]  IRQ_ENABLE_CLEAR   = 8'h44;
    localparam logic [7:0]  IRQ_MASK_STATE     = 8'h48;
    localparam logic [7:0]  IRQ_PENDING_STATE  = 8'h4C;
    localparam logic [7:0]  OPEN_DRAIN_SET     = 8'h50;
    localparam logic [7:0]  OPEN_DRAIN_CLEAR   = 8'h54;
    localparam logic [7:0]  OPEN_DRAIN_STATE   = 8'h58;
    localparam logic [7:0]  PULLUP_CLEAR       = 8'h60;
    localparam logic [7:0]  PULLUP_SET         = 8'h64;
    localparam logic [7:0]  PULLUP_STATE       = 8'h68;
    // own choice: writes to out_level_state allowed only where this write mask is set
    localparam logic [7:0]  OUT_WRITE_ENABLE   = 8'h70;
    localparam logic [7:0]  OUT_WRITE_DISABLE  = 8'h74;
    localparam logic [7:0]  OUT_WRITE_STATE    = 8'h78;
    // implemented lines and lines carrying a peripheral; arbitrary defaults
    localparam logic [31:0] LINES_PRESENT      = 32'hFFFFFFFF;
    localparam logic [31:0] LINES_MUXED        = 32'h0000FFFF;
    localparam logic [31:0] RESET_ZERO         = 32'h00000000;
    localparam logic [31:0] LINE_CTRL_RESET    = 32'hFFFFFFFF;
    localparam int          FILTER_STAGES      = 2;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_s;
endpackage : pio_line_pkg

// File: design/pio_glitch_filter.sv
// per-line input glitch filter: a level passes only after it is stable over the stages
// assumes pin inputs already synchronous to mclk
`timescale 1ns/100ps
module pio_glitch_filter
    import pio_line_pkg::*;
(
    input  wire logic                 mclk,      // system clock
    input  wire logic                 rst_b,     // async reset, active low
    input  wire logic [NUM_LINES-1:0] raw_in,    // sampled pin levels
    input  wire logic [NUM_LINES-1:0] filt_en,   // per-line filter enable
    output logic      [NUM_LINES-1:0] level_out  // filtered levels
);
    logic [NUM_LINES-1:0] hist_q [FILTER_STAGES];
    logic [NUM_LINES-1:0] stable_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < FILTER_STAGES; i++) hist_q[i] <= RESET_ZERO;
        end else begin
            hist_q[0] <= raw_in;
            for (int i = 1; i < FILTER_STAGES; i++) hist_q[i] <= hist_q[i-1];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_LINES; g++) begin : gen_line
            // pulses shorter than the history depth are swallowed
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    stable_q[g] <= 1'b0;
                end else if (hist_q[0][g] == hist_q[FILTER_STAGES-1][g]) begin
                    stable_q[g] <= hist_q[0][g];
                end
            end
            assign level_out[g] = filt_en[g] ? stable_q[g] : raw_in[g];
        end
    endgenerate
endmodule : pio_glitch_filter

// File: testbench/io_pad_model.sv
// pad wires and peripheral side of every line, seen from outside the controller
// assumes pad outputs are combinational and that the bench drives ext_* on mclk edges
`timescale 1ns/100ps
module io_pad_model
    import pio_line_pkg::*;
(
    input  wire logic [NUM_LINES-1:0] pin_out,    // controller pad data
    input  wire logic [NUM_LINES-1:0] pin_oe,     // controller drive enables
    input  wire logic [NUM_LINES-1:0] pin_pullup, // pull-up enables
    input  wire logic [NUM_LINES-1:0] ext_val,    // level of the outside driver
    input  wire logic [NUM_LINES-1:0] ext_en,     // outside driver enables
    input  wire logic [NUM_LINES-1:0] per_oe_cfg, // peripheral enables wanted
    output logic      [NUM_LINES-1:0] pin_in,     // resolved pad level
    output logic      [NUM_LINES-1:0] periph_out, // peripheral data
    output logic      [NUM_LINES-1:0] periph_oe   // peripheral enables
);
    // a floating line without pull-up shows the inverse of the outside level, never a stale copy
    assign pin_in     = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                      | (~pin_oe & ~ext_en & (pin_pullup | ~ext_val));
    assign periph_out = ~ext_val;
    assign periph_oe  = per_oe_cfg;
endmodule : io_pad_model

// File: testbench/parallel_io_line_controller_tb_top.sv
// self-checking bench for the line controller: register tasks, pad model, interrupt
// assumes the single-cycle register port with read data in the cycle after the strobe
`timescale 1ns/100ps
module parallel_io_line_controller_tb_top;
    import pio_line_pkg::*;
    logic                 mclk = 1'b0;
    logic                 rst_b = 1'b0;
    logic [7:0]           reg_addr = 8'h00;
    logic [31:0]          reg_wdata = 32'h00000000;
    logic                 reg_wr = 1'b0;
    logic                 reg_rd = 1'b0;
    logic [31:0]          reg_rdata;
    logic [NUM_LINES-1:0] pin_in, pin_out, pin_oe, pin_pullup, periph_out, periph_oe, periph_in;
    logic [NUM_LINES-1:0] ext_val = '0;
    logic [NUM_LINES-1:0] ext_en = '1;
    logic [NUM_LINES-1:0] per_oe_cfg = 32'h000000FF;
    logic                 irq;
    int                   num_errors = 0;
    int                   n_compared = 0;
    int                   cycles = 0;
    logic [31:0]          d;
    logic [7:0] st_a [8] = '{LINE_CTRL_STATUS, DRIVE_ENABLE_STATE, GLITCH_FILTER_STATE,
        IRQ_MASK_STATE, IRQ_PENDING_STATE, OPEN_DRAIN_STATE, PULLUP_STATE, OUT_WRITE_STATE};
    logic [7:0] s_a [5] = '{DRIVE_ENABLE_SET, GLITCH_FILTER_SET, IRQ_ENABLE_SET, OPEN_DRAIN_SET,
        PULLUP_SET};
    logic [7:0] c_a [5] = '{DRIVE_ENABLE_CLEAR, GLITCH_FILTER_CLEAR, IRQ_ENABLE_CLEAR,
        OPEN_DRAIN_CLEAR, PULLUP_CLEAR};
    logic [7:0] r_a [5] = '{DRIVE_ENABLE_STATE, GLITCH_FILTER_STATE, IRQ_MASK_STATE,
        OPEN_DRAIN_STATE, PULLUP_STATE};

    always #12.5 mclk = ~mclk;

    pio_line_ctrl uut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_in(periph_in), .irq(irq));
    io_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .ext_val(ext_val), .ext_en(ext_en), .per_oe_cfg(per_oe_cfg), .pin_in(pin_in),
        .periph_out(periph_out), .periph_oe(periph_oe));

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk32

    task automatic chk1(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a, d);
        chk32($sformatf("reg %h", a), exp, d);
    endtask : rdc

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            finish_test();
        end
    end

    initial begin
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++)
            rdc(st_a[i], (i == 0) ? LINES_PRESENT : RESET_ZERO);
        chk32("pin_pullup", RESET_ZERO, pin_pullup);
        $display("test reset_values done");
        for (int i = 0; i < 5; i++) begin
            wr(s_a[i], 32'h5A5AC3C3);
            wr(c_a[i], 32'h0000C3C3);
            rdc(r_a[i], 32'h5A5A0000 & LINES_PRESENT);
            if (i == 4)
                chk32("pin_pullup", 32'h5A5A0000 & LINES_PRESENT, pin_pullup);
            wr(c_a[i], 32'hFFFFFFFF);
            rdc(r_a[i], RESET_ZERO);
        end
        wr(PULLUP_SET, 32'h00000081);
        rdc(PULLUP_STATE, 32'h00000081);
        wr(PULLUP_CLEAR, 32'hFFFFFFFF);
        $display("test set_clear done");
        rdc(GLITCH_FILTER_SET, RESET_ZERO);
        rdc(8'h0C, RESET_ZERO);
        wr(GLITCH_FILTER_STATE, 32'hFFFFFFFF);
        rdc(GLITCH_FILTER_STATE, RESET_ZERO);
        $display("test refused_access done");
        wr(LINE_CTRL_DISABLE, 32'hFFFFFFFF);
        rdc(LINE_CTRL_STATUS, ~LINES_MUXED & LINES_PRESENT);
        chk32("pin_oe", per_oe_cfg & LINES_MUXED, pin_oe);
        wr(LINE_CTRL_ENABLE, 32'hFFFFFFFF);
        rdc(LINE_CTRL_STATUS, LINES_PRESENT);
        $display("test ownership done");
        wr(OUT_LEVEL_SET, 32'h000000F0);
        wr(OUT_LEVEL_STATE, 32'h0000000F);
        rdc(OUT_LEVEL_STATE, 32'h000000F0);
        wr(OUT_WRITE_ENABLE, 32'h0000000F);
        wr(OUT_LEVEL_STATE, 32'h0000000A);
        rdc(OUT_LEVEL_STATE, 32'h000000FA);
        chk32("pin_out", 32'h000000FA, pin_out);
        wr(OUT_LEVEL_CLEAR, 32'h000000FF);
        rdc(OUT_LEVEL_STATE, RESET_ZERO);
        $display("test direct_output done");
        wr(IRQ_ENABLE_SET, 32'h00100000);
        rd(IRQ_PENDING_STATE, d);
        @(posedge mclk);
        ext_val[20] <= 1'b1;
        for (int i = 0; i < 10 && irq !== 1'b1; i++)
            @(posedge mclk) #1;
        chk1("irq", 1'b1, irq);
        chk32("periph_in", 32'h00100000, periph_in);
        rdc(IRQ_PENDING_STATE, 32'h00100000);
        rdc(IRQ_PENDING_STATE, RESET_ZERO);
        chk1("irq", 1'b0, irq);
        wr(IRQ_ENABLE_CLEAR, 32'h00100000);
        ext_val[20] <= 1'b0;
        repeat (6) @(posedge mclk);
        #1 chk1("irq", 1'b0, irq);
        rdc(IRQ_PENDING_STATE, 32'h00100000);
        $display("test interrupt done");
        finish_test();
    end
endmodule : parallel_io_line_controller_tb_top
